/* File: core/tdc_trap_unit.sv */
// Trap detection, ranking, nesting and the timed interrupt mask
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// Functional notes
// RULE1: Each source has fixed rank; clock loss highest, DMA collision lowest.
// RULE2: DMA collision, math and stack traps are soft, levels 10, 11, 12.
// RULE3: Soft traps need two cycles of sampling before they are presented.
// RULE4: Stack pointer resets to 0x0800; pointer below 0x0800 raises stack trap.
// RULE5: Stack limit is uninitialised; overflow check idle until a word write.
// RULE6: Every stack pointer EA above the limit raises a stack trap.
// RULE7: A stack pointer EA wrapping past 0xFFFF raises a stack trap.
// RULE8: Stack fault flag is bit 2; software clears it before returning.
// RULE9: Divide by zero always traps, checked on first repeat iteration.
// RULE10: Divide sets bits 6 and 4; bit 4 clears only after bit 6.
// RULE11: CPU wins same-address write collision, DMA dropped, bit 5 set.
// RULE12: Levels 13-15 are hard; address error 13, clock loss 14.
// RULE13: Hard trap halts execution until acknowledged and processed.
// RULE14: Higher trap preempts lower; lower stays pending until higher ends.
// RULE15: Lower hard trap under higher activity resets device, sets bit 15.
// RULE16: Clock loss trap from monitor, lost PLL lock, or no lock at POR.
// RULE17: Clock loss sets bit 1 and clock fail status; software clears.
// RULE18: Odd word EA, odd indirect bit op, unimplemented space raise address trap.
// RULE19: Address trap inhibits data writes and sets bit 3; software clears.
// RULE20: Timed mask hits levels 1-6 only, up to 16384 cycles; traps pass. The 14-bit count here masks at most 16383 cycles.
// RULE21: Non-zero countdown masks and decrements each cycle; bit 14 shows it.
// RULE22: Countdown read/write; clear ends early; write from zero never starts.
// RULE23: Trap levels 8-15 sit above all user interrupt levels.
// RULE24: Trap level bit set in service; software may clear, never set.
// RULE25: Flags stay set until cleared and keep their trap requested.
module tdc_trap_unit #(
  parameter int CNT_W = tdc_pkg::COUNT_W
) (
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire logic [4:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic                  monitor_enable,
  input  wire logic                  pll_mode,
  input  wire logic                  clk_loss_pin,
  input  wire logic                  pll_unlock_pin,
  input  wire logic                  por_no_lock_pin,
  input  wire tdc_pkg::tdc_core_in_t core_in,
  output tdc_pkg::tdc_core_out_t     core_out
);

  localparam int N = tdc_pkg::NSRC;

  // Highest set bit of a source vector, or none
  function automatic logic [2:0] top_src(input logic [N-1:0] v);
    logic [2:0] r;
    r = 3'h7;
    for (int i = 0; i < N; i++) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // Mask of the sources ranked above a given index
  function automatic logic [N-1:0] above(input logic [2:0] idx);
    logic [N-1:0] m;
    m = '0;
    for (int i = 0; i < N; i++) begin
      if (3'(i) > idx) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // Flags and state
  logic [N-1:0]     flag_reg, flag_next;
  logic             div0_reg, div0_next;
  logic [N-1:0]     svc_reg, svc_next;
  logic [N-1:0]     soft_s1_reg, soft_s2_reg;
  logic             conflict_reg, conflict_next;
  logic             clk_fail_reg, clk_fail_next;
  logic             lvlbit_reg, lvlbit_next;
  logic             reset_req_reg;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [15:0]      sp_reg, sp_next;
  logic [15:0]      limit_reg;
  logic             limit_on_reg;
  logic             ack_reg;
  logic [31:0]      rdata_reg;
  logic [2:0]       osc_s1_reg, osc_s2_reg, osc_s3_reg;
  logic [2:0]       osc_lvl_reg;

  // Avalon decode: one wait state; a write lands only at the edge where
  // waitrequest is low, so a master that waits never sees it early
  wire bus_req   = avs_read | avs_write;
  wire bus_take  = bus_req & ~ack_reg;
  wire word_en   = avs_byteenable[1:0] == 2'b11;
  wire wr_take   = avs_write & ack_reg & word_en;
  wire wr_ctl1   = wr_take & (avs_address == tdc_pkg::OFS_CTL_ONE);
  wire wr_cnt    = wr_take & (avs_address == tdc_pkg::OFS_COUNT);
  wire wr_limit  = wr_take & (avs_address == tdc_pkg::OFS_LIMIT);
  wire wr_sp     = wr_take & (avs_address == tdc_pkg::OFS_SP);
  wire wr_rst    = wr_take & (avs_address == tdc_pkg::OFS_RST_CTL);
  wire wr_osc    = wr_take & (avs_address == tdc_pkg::OFS_OSC_CTL);
  wire wr_core   = wr_take & (avs_address == tdc_pkg::OFS_CORE);
  wire [15:0] wd = avs_writedata[15:0];

  // Pin conditions agree over two stages before they count
  wire [2:0] osc_agree = osc_s2_reg & osc_s3_reg;
  wire [2:0] osc_rise  = osc_agree & ~osc_lvl_reg;
  wire osc_event = (osc_rise[0] & monitor_enable)        // RULE16
                 | (osc_rise[1] & pll_mode)
                 | (osc_rise[2] & monitor_enable);

  // Stack checks
  wire sp_low    = sp_reg < tdc_pkg::STACK_FLOOR;         // RULE4
  wire ea_over   = core_in.sp_ea_valid & limit_on_reg
                 & (core_in.sp_ea > limit_reg);           // RULE6
  wire ea_wrap   = core_in.sp_ea_valid & core_in.sp_ea_wrap; // RULE7
  wire stack_ev  = sp_low | ea_over | ea_wrap;

  // Same-address collision: CPU keeps the slot, DMA write is dropped
  wire dma_coll  = core_in.cpu_wr & core_in.dma_wr
                 & (core_in.cpu_wr_addr == core_in.dma_wr_addr); // RULE11
  wire addr_ev   = core_in.word_odd | core_in.bit_ind_odd
                 | core_in.data_unimpl | core_in.prog_unimpl;  // RULE18

  // New events per source, in rank order
  wire [N-1:0] ev;
  assign ev[tdc_pkg::SRC_DMA]   = dma_coll;
  assign ev[tdc_pkg::SRC_MATH]  = core_in.div_zero_first; // RULE9
  assign ev[tdc_pkg::SRC_STACK] = stack_ev;
  assign ev[tdc_pkg::SRC_ADDR]  = addr_ev;
  assign ev[tdc_pkg::SRC_OSC]   = osc_event;

  // Hard class is the address and clock loss sources
  wire [N-1:0] hard_mask = above(3'(tdc_pkg::FIRST_HARD - 1)); // RULE12
  wire [N-1:0] soft_mask = ~hard_mask;                          // RULE2

  // Conflict: a new hard event below any pending or active trap
  wire [N-1:0] busy     = flag_reg | svc_reg;
  wire [N-1:0] hard_new = ev & hard_mask & ~flag_reg;
  logic conflict_hit;
  always_comb begin
    conflict_hit = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (hard_new[i] && |(busy & above(3'(i)))) begin
        conflict_hit = 1'b1;                               // RULE15
      end
    end
  end

  // Requests: soft ones only after the two sampling stages
  wire [N-1:0] visible = (flag_reg & hard_mask)
                       | (soft_s2_reg & flag_reg);         // RULE3 RULE25
  wire [N-1:0] waiting = visible & ~svc_reg;
  wire [2:0]   cur_src = top_src(svc_reg);
  wire [2:0]   req_src = top_src(waiting);
  wire [N-1:0] beat    = svc_reg == '0 ? waiting
                       : waiting & above(cur_src);         // RULE14
  wire [2:0]   win_src = top_src(beat);                    // RULE1
  wire         req_on  = beat != '0;

  // Flag update: hardware set wins over software clear
  always_comb begin
    flag_next = flag_reg;
    div0_next = div0_reg | core_in.div_zero_first;         // RULE10
    if (wr_ctl1) begin
      div0_next = (div0_reg & wd[tdc_pkg::BIT_DIV0]) | core_in.div_zero_first;
      flag_next[tdc_pkg::SRC_DMA]   = flag_reg[tdc_pkg::SRC_DMA]   & wd[tdc_pkg::BIT_DMA];
      flag_next[tdc_pkg::SRC_STACK] = flag_reg[tdc_pkg::SRC_STACK] & wd[tdc_pkg::BIT_STACK];
      flag_next[tdc_pkg::SRC_ADDR]  = flag_reg[tdc_pkg::SRC_ADDR]  & wd[tdc_pkg::BIT_BAD_ADDR];
      flag_next[tdc_pkg::SRC_OSC]   = flag_reg[tdc_pkg::SRC_OSC]   & wd[tdc_pkg::BIT_CLK_LOSS];
      // Math flag only drops once its cause bit is gone
      flag_next[tdc_pkg::SRC_MATH]  = flag_reg[tdc_pkg::SRC_MATH]
                                    & (wd[tdc_pkg::BIT_ARITH] | div0_next); // RULE10
    end
    flag_next = flag_next | ev;                            // RULE8 RULE17 RULE19 RULE25
  end

  // Service stack: ack adds the winner, return drops the top one
  always_comb begin
    svc_next = svc_reg;
    if (core_in.trap_return && svc_reg != '0) begin
      svc_next[cur_src] = 1'b0;                            // RULE14
    end
    if (core_in.trap_ack && req_on) begin
      svc_next[win_src] = 1'b1;
    end
  end

  // Trap level bit: set on entry, software may only clear it
  always_comb begin
    lvlbit_next = lvlbit_reg;
    if (wr_core && !wd[tdc_pkg::BIT_TRAP_LVL]) begin
      lvlbit_next = 1'b0;                                  // RULE24
    end
    if (core_in.trap_return && svc_next == '0) begin
      lvlbit_next = 1'b0;
    end
    if (core_in.trap_ack && req_on) begin
      lvlbit_next = 1'b1;
    end
  end

  // Timed mask countdown; a bus write cannot start it from zero
  always_comb begin
    cnt_next = cnt_reg;
    if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;                           // RULE21
    end
    if (wr_cnt && cnt_reg != '0) begin
      cnt_next = wd[CNT_W-1:0];                            // RULE22
    end
    if (core_in.mask_instr) begin
      cnt_next = core_in.mask_count[CNT_W-1:0];            // RULE20
    end
  end

  // Conflict and clock fail flags, set wins over clear
  always_comb begin
    conflict_next = conflict_reg;
    if (wr_rst && !wd[tdc_pkg::BIT_CONFLICT]) begin
      conflict_next = 1'b0;
    end
    conflict_next = conflict_next | conflict_hit;          // RULE15
    clk_fail_next = clk_fail_reg;
    if (wr_osc && !wd[tdc_pkg::BIT_CLK_FAIL]) begin
      clk_fail_next = 1'b0;
    end
    clk_fail_next = clk_fail_next | osc_event;             // RULE17
  end

  // Stack pointer: core loads win over bus writes
  always_comb begin
    sp_next = sp_reg;
    if (wr_sp) begin
      sp_next = wd;
    end
    if (core_in.sp_load) begin
      sp_next = core_in.sp_value;
    end
  end

  // Read mux; unmapped offsets read zero
  logic [15:0] rd_word;
  always_comb begin
    rd_word = '0;
    case (avs_address)
      tdc_pkg::OFS_CTL_ONE: begin
        rd_word[tdc_pkg::BIT_CLK_LOSS] = flag_reg[tdc_pkg::SRC_OSC];
        rd_word[tdc_pkg::BIT_STACK]    = flag_reg[tdc_pkg::SRC_STACK];
        rd_word[tdc_pkg::BIT_BAD_ADDR] = flag_reg[tdc_pkg::SRC_ADDR];
        rd_word[tdc_pkg::BIT_ARITH]    = flag_reg[tdc_pkg::SRC_MATH];
        rd_word[tdc_pkg::BIT_DMA]      = flag_reg[tdc_pkg::SRC_DMA];
        rd_word[tdc_pkg::BIT_DIV0]     = div0_reg;
      end
      tdc_pkg::OFS_CTL_TWO: rd_word[tdc_pkg::BIT_MASK_ON] = cnt_reg != '0; // RULE21
      tdc_pkg::OFS_COUNT:   rd_word[CNT_W-1:0] = cnt_reg;
      tdc_pkg::OFS_LIMIT:   rd_word = limit_reg;
      tdc_pkg::OFS_SP:      rd_word = sp_reg;
      tdc_pkg::OFS_RST_CTL: rd_word[tdc_pkg::BIT_CONFLICT] = conflict_reg;
      tdc_pkg::OFS_OSC_CTL: rd_word[tdc_pkg::BIT_CLK_FAIL] = clk_fail_reg;
      tdc_pkg::OFS_CORE:    rd_word[tdc_pkg::BIT_TRAP_LVL] = lvlbit_reg;
      default:              rd_word = '0;
    endcase
  end

  // Bus handshake and read data register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg   <= bus_take;
      rdata_reg <= {16'h0000, rd_word};
    end
  end

  // Pin synchronisers for the oscillator conditions
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      osc_s1_reg  <= '0;
      osc_s2_reg  <= '0;
      osc_s3_reg  <= '0;
      osc_lvl_reg <= '0;
    end else begin
      osc_s1_reg  <= {por_no_lock_pin, pll_unlock_pin, clk_loss_pin};
      osc_s2_reg  <= osc_s1_reg;
      osc_s3_reg  <= osc_s2_reg;
      osc_lvl_reg <= (osc_s2_reg == osc_s3_reg) ? osc_agree : osc_lvl_reg;
    end
  end

  // Trap state; a conflict clears nesting state as the device resets
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flag_reg    <= '0;
      div0_reg    <= 1'b0;
      svc_reg     <= '0;
      soft_s1_reg <= '0;
      soft_s2_reg <= '0;
      lvlbit_reg  <= 1'b0;
    end else if (conflict_hit) begin
      flag_reg    <= '0;                                   // RULE15
      div0_reg    <= 1'b0;
      svc_reg     <= '0;
      soft_s1_reg <= '0;
      soft_s2_reg <= '0;
      lvlbit_reg  <= 1'b0;
    end else begin
      flag_reg    <= flag_next;
      div0_reg    <= div0_next;
      svc_reg     <= svc_next;
      soft_s1_reg <= flag_reg & soft_mask;                 // RULE3
      soft_s2_reg <= soft_s1_reg & flag_reg;
      lvlbit_reg  <= lvlbit_next;
    end
  end

  // Reset flag survives the conflict reset so software can see it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      conflict_reg  <= 1'b0;
      clk_fail_reg  <= 1'b0;
      reset_req_reg <= 1'b0;
      cnt_reg       <= '0;
      sp_reg        <= tdc_pkg::SP_RESET;                  // RULE4
    end else begin
      conflict_reg  <= conflict_next;
      clk_fail_reg  <= clk_fail_next;
      reset_req_reg <= conflict_hit;
      cnt_reg       <= cnt_next;
      sp_reg        <= sp_next;
    end
  end

  // Limit keeps no reset value; only the enable is reset
  always_ff @(posedge sys_clk) begin
    if (wr_limit) begin
      limit_reg <= wd;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      limit_on_reg <= 1'b0;
    end else if (wr_limit) begin
      limit_on_reg <= 1'b1;                                // RULE5
    end
  end

  // Outputs; trap levels always exceed every user level
  assign avs_waitrequest = bus_req & ~ack_reg;
  assign avs_readdata    = rdata_reg;
  assign core_out.trap_req   = req_on;
  assign core_out.trap_level = req_on ? tdc_pkg::LEVEL_BASE + 4'(win_src)
                                      : 4'h0;              // RULE23
  assign core_out.hard_halt  = |(flag_reg & hard_mask & ~svc_reg); // RULE13
  assign core_out.dma_write_drop     = dma_coll;           // RULE11
  assign core_out.data_write_inhibit = addr_ev | flag_reg[tdc_pkg::SRC_ADDR]; // RULE19
  assign core_out.irq_mask_low       = cnt_reg != '0;      // RULE20
  assign core_out.device_reset_req   = reset_req_reg;
  assign core_out.trap_level_bit     = lvlbit_reg;

  wire unused_ok = ^{req_src, avs_writedata[31:16], avs_byteenable[3:2]};
endmodule

/* File: shared/tdc_pkg.sv */
// Shared constants and carrier types for the trap and timed mask unit
package tdc_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] OFS_CTL_ONE = 5'h00;
  localparam logic [4:0] OFS_CTL_TWO = 5'h04;
  localparam logic [4:0] OFS_COUNT   = 5'h08;
  localparam logic [4:0] OFS_LIMIT   = 5'h0c;
  localparam logic [4:0] OFS_SP      = 5'h10;
  localparam logic [4:0] OFS_RST_CTL = 5'h14;
  localparam logic [4:0] OFS_OSC_CTL = 5'h18;
  localparam logic [4:0] OFS_CORE    = 5'h1c;
  // Field positions
  localparam int BIT_CLK_LOSS = 1;
  localparam int BIT_STACK    = 2;
  localparam int BIT_BAD_ADDR = 3;
  localparam int BIT_ARITH    = 4;
  localparam int BIT_DMA      = 5;
  localparam int BIT_DIV0     = 6;
  localparam int BIT_MASK_ON  = 14;
  localparam int BIT_CONFLICT = 15;
  localparam int BIT_CLK_FAIL = 3;
  localparam int BIT_TRAP_LVL = 3;
  // Source index, lowest rank first; trap level is base plus index
  localparam int SRC_DMA   = 0;
  localparam int SRC_MATH  = 1;
  localparam int SRC_STACK = 2;
  localparam int SRC_ADDR  = 3;
  localparam int SRC_OSC   = 4;
  localparam int NSRC      = 5;
  localparam int FIRST_HARD = SRC_ADDR;
  localparam logic [3:0] LEVEL_BASE = 4'ha;
  // Reset values and limits
  localparam logic [15:0] SP_RESET   = 16'h0800;
  localparam logic [15:0] STACK_FLOOR = 16'h0800;
  localparam int COUNT_W = 14;
  localparam int SOFT_SAMPLE_CYCLES = 2;
  // Signals from the processor core, all on sys_clk
  typedef struct packed {
    logic        mask_instr;       // timed_irq_mask_instr executes
    logic [13:0] mask_count;
    logic        sp_load;
    logic [15:0] sp_value;
    logic        sp_ea_valid;      // EA formed with stack_pointer_reg
    logic [15:0] sp_ea;
    logic        sp_ea_wrap;       // EA carry past the top of data space
    logic        div_zero_first;   // divide by zero, first repeat pass
    logic        cpu_wr;
    logic [15:0] cpu_wr_addr;
    logic        dma_wr;
    logic [15:0] dma_wr_addr;
    logic        word_odd;
    logic        bit_ind_odd;
    logic        data_unimpl;
    logic        prog_unimpl;
    logic        trap_ack;
    logic        trap_return;      // return_from_exception of a trap
  } tdc_core_in_t;
  typedef struct packed {
    logic       trap_req;
    logic [3:0] trap_level;
    logic       hard_halt;
    logic       dma_write_drop;
    logic       data_write_inhibit;
    logic       irq_mask_low;      // levels 1..6 masked
    logic       device_reset_req;
    logic       trap_level_bit;
  } tdc_core_out_t;
endpackage

/* File: verif/tdc_trap_checker.sv */
// Concurrent checks on the trap unit ports
`timescale 1ns/100ps
module tdc_trap_checker #(
  parameter int CNT_W = tdc_pkg::COUNT_W
) (
  input wire logic                   sys_clk,
  input wire logic                   nrst,
  input wire tdc_pkg::tdc_core_in_t  core_in,
  input wire tdc_pkg::tdc_core_out_t core_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Shared decodes of the core side causes
  wire collide = core_in.cpu_wr && core_in.dma_wr
                 && (core_in.cpu_wr_addr == core_in.dma_wr_addr);
  wire addr_evt = core_in.word_odd || core_in.bit_ind_odd
                  || core_in.data_unimpl || core_in.prog_unimpl;
  wire idle = !core_out.trap_req && !core_out.trap_level_bit;
  // Soft trap stays quiet two cycles before it is presented
  sequence soft_quiet_s;
    !core_out.trap_req [*2];
  endsequence
  sequence math_up_s;
    core_out.trap_req && core_out.trap_level == 4'hb;
  endsequence
  // A count of three masks exactly three cycles
  sequence mask_three_s;
    core_out.irq_mask_low [*3] ##1 !core_out.irq_mask_low;
  endsequence
  AST_SOFT_DELAY: assert property (core_in.div_zero_first && idle |=> soft_quiet_s ##1 math_up_s)
    else $error("soft trap timing wrong");
  AST_MASK_RUN: assert property (core_in.mask_instr && core_in.mask_count == 14'h0003
    |=> mask_three_s) else $error("mask length wrong");
  AST_MASK_NO_START: assert property (!core_out.irq_mask_low && !core_in.mask_instr
    |=> !core_out.irq_mask_low) else $error("mask started without instruction");
  AST_DROP: assert property (collide |-> core_out.dma_write_drop)
    else $error("dma write not dropped");
  AST_INHIBIT: assert property (addr_evt |-> core_out.data_write_inhibit)
    else $error("data write not inhibited");
  AST_HARD_ADDR: assert property (core_in.word_odd && idle
    |=> core_out.trap_req && core_out.trap_level == 4'hd) else $error("address trap missing");
  AST_LEVEL_RANGE: assert property (core_out.trap_req
    |-> core_out.trap_level inside {[4'ha:4'he]}) else $error("trap level out of range");
  AST_ACK_BIT: assert property (core_in.trap_ack && core_out.trap_req
    |=> core_out.trap_level_bit) else $error("trap level bit not set");
  AST_HALT_ACK: assert property (core_in.trap_ack && core_out.hard_halt
    |=> !core_out.hard_halt) else $error("halt kept after ack");
  AST_RST_PULSE: assert property ($rose(core_out.device_reset_req)
    |=> !core_out.device_reset_req) else $error("reset request not one cycle");
endmodule

bind tdc_trap_unit tdc_trap_checker #(.CNT_W(CNT_W)) i_chk (
  .sys_clk  (sys_clk),
  .nrst     (nrst),
  .core_in  (core_in),
  .core_out (core_out)
);

/* File: verif/tdc_core_model.sv */
// Behavioural core: acknowledges traps and returns from them
`timescale 1ns/100ps
module tdc_core_model (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       trap_req,
  input  wire logic       dev_rst,
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_dly,
  input  wire logic       ret_cmd,
  output logic            trap_ack,
  output logic            trap_return
);
  logic [3:0] wait_cnt;
  logic       ack_now;
  logic       ret_now;
  int         depth;
  // Ack after a chosen delay; a return is only sent for a trap taken
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      trap_ack <= 1'b0;
      trap_return <= 1'b0;
      wait_cnt <= 4'h0;
      depth <= 0;
    end else begin
      ack_now = trap_req && ack_en && !trap_ack && wait_cnt >= ack_dly;
      ret_now = ret_cmd && depth > 0;
      trap_ack <= ack_now;
      trap_return <= ret_now;
      wait_cnt <= (trap_req && ack_en && !ack_now) ? wait_cnt + 4'h1 : 4'h0;
      depth <= dev_rst ? 0 : depth + int'(ack_now) - int'(ret_now);
    end
  end
endmodule

/* File: verif/tdc_trap_unit_tb.sv */
// Self-checking bench for the trap unit
`timescale 1ns/100ps
module tdc_trap_unit_tb;
  logic                   sys_clk = 1'b0;
  logic                   nrst = 1'b0;
  logic [4:0]             adr = 5'h00;
  logic                   rd = 1'b0;
  logic                   wr = 1'b0;
  logic [31:0]            wdat = 32'h0;
  logic [31:0]            rdat;
  logic                   wreq;
  logic [2:0]             pins = 3'h0;
  logic                   ack_en = 1'b1;
  logic                   mon_en = 1'b1;
  logic                   pll_on = 1'b1;
  logic [3:0]             ack_dly = 4'h1;
  logic                   ret_cmd = 1'b0;
  logic                   m_ack;
  logic                   m_ret;
  tdc_pkg::tdc_core_in_t  cin = '0;
  tdc_pkg::tdc_core_in_t  ci;
  tdc_pkg::tdc_core_out_t co;
  int                     mismatches = 0;
  int                     tests_run = 0;
  logic [31:0]            rdv;
  always #50 sys_clk = ~sys_clk;
  // Acknowledge and return come from the core model
  always_comb begin
    ci = cin;
    ci.trap_ack = m_ack;
    ci.trap_return = m_ret;
  end
  tdc_trap_unit i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hf),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .monitor_enable(mon_en),
    .pll_mode(pll_on), .clk_loss_pin(pins[0]), .pll_unlock_pin(pins[1]),
    .por_no_lock_pin(pins[2]), .core_in(ci), .core_out(co));
  tdc_core_model i_core (
    .sys_clk(sys_clk), .nrst(nrst), .trap_req(co.trap_req), .dev_rst(co.device_reset_req),
    .ack_en(ack_en), .ack_dly(ack_dly), .ret_cmd(ret_cmd), .trap_ack(m_ack),
    .trap_return(m_ret));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Avalon cycle: hold until waitrequest low, take data, then release
  // Waitrequest and read data are taken at the rising edge itself
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    do begin
      @(posedge sys_clk);
    end while (wreq !== 1'b0);
    rdv = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask
  task automatic pulse(input tdc_pkg::tdc_core_in_t p);
    @(posedge sys_clk);
    cin <= p;
    @(posedge sys_clk);
    cin <= '0;
  endtask
  task automatic svc_return;
    @(posedge sys_clk);
    ret_cmd <= 1'b1;
    @(posedge sys_clk);
    ret_cmd <= 1'b0;
  endtask
  // One core event; a collision only when the address is 0100
  function automatic tdc_pkg::tdc_core_in_t mk(input int k, input logic [15:0] v);
    mk = '0;
    case (k)
      1: mk.sp_ea_wrap = 1'b1;
      2: mk.sp_load = 1'b1;
      3: mk.div_zero_first = 1'b1;
      4: mk.dma_wr = 1'b1;
      5: mk.word_odd = 1'b1;
      6: mk.bit_ind_odd = 1'b1;
      7: mk.data_unimpl = 1'b1;
      8: mk.prog_unimpl = 1'b1;
      9: mk.mask_instr = 1'b1;
      default: mk.sp_ea_valid = 1'b1;
    endcase
    mk.sp_ea_valid = (k < 2);
    mk.sp_ea = v;
    mk.sp_value = v;
    mk.mask_count = v[13:0];
    mk.cpu_wr = (k == 4);
    mk.cpu_wr_addr = v;
    mk.dma_wr_addr = 16'h0100;
  endfunction
  // Event, flag check, then software clears and returns
  task automatic ev_chk(input int k, input logic [15:0] v, input logic [31:0] e);
    pulse(mk(k, v));
    repeat (4) @(posedge sys_clk);
    rd_chk(tdc_pkg::OFS_CTL_ONE, e);
    pulse(mk(2, tdc_pkg::SP_RESET));
    bus(1'b1, tdc_pkg::OFS_CTL_ONE, 32'h0);
    svc_return();
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    rd_chk(tdc_pkg::OFS_SP, 32'h0800);
    rd_chk(5'h1e, 32'h0);
    bus(1'b1, tdc_pkg::OFS_COUNT, 32'h5);
    rd_chk(tdc_pkg::OFS_CTL_TWO, 32'h0);
    pulse(mk(9, 16'h0003));
    repeat (5) @(posedge sys_clk);
    pulse(mk(9, 16'h00c8));
    rd_chk(tdc_pkg::OFS_CTL_TWO, 32'h4000);
    // Divide by zero still traps while the mask is active
    ack_en <= 1'b0;
    pulse(mk(3, 16'h0));
    repeat (4) @(negedge sys_clk);
    chk({co.irq_mask_low, co.trap_req, co.trap_level}, 32'h3b);
    rd_chk(tdc_pkg::OFS_CTL_ONE, 32'h50);
    bus(1'b1, tdc_pkg::OFS_CTL_ONE, 32'h40);
    rd_chk(tdc_pkg::OFS_CTL_ONE, 32'h50);
    bus(1'b1, tdc_pkg::OFS_COUNT, 32'h0);
    rd_chk(tdc_pkg::OFS_CTL_TWO, 32'h0);
    ack_en <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd_chk(tdc_pkg::OFS_CORE, 32'h8);
    bus(1'b1, tdc_pkg::OFS_CORE, 32'h0);
    bus(1'b1, tdc_pkg::OFS_CORE, 32'h8);
    rd_chk(tdc_pkg::OFS_CORE, 32'h0);
    bus(1'b1, tdc_pkg::OFS_CTL_ONE, 32'h0);
    svc_return();
    rd_chk(tdc_pkg::OFS_CTL_ONE, 32'h0);
    // Stack, collision and address causes with a slow core
    ack_dly <= 4'h3;
    ev_chk(0, 16'hf000, 32'h0);
    bus(1'b1, tdc_pkg::OFS_LIMIT, 32'h0900);
    ev_chk(0, 16'h0900, 32'h0);
    ev_chk(0, 16'h0902, 32'h4);
    ev_chk(1, 16'h0010, 32'h4);
    ev_chk(2, 16'h07fe, 32'h4);
    ev_chk(4, 16'h0100, 32'h20);
    ev_chk(4, 16'h0102, 32'h0);
    for (int k = 5; k < 9; k++) ev_chk(k, 16'h0, 32'h8);
    // Monitor and PLL mode off: no pin cause may trap
    {mon_en, pll_on} <= 2'b00;
    @(posedge sys_clk);
    pins <= 3'h7;
    repeat (6) @(posedge sys_clk);
    pins <= 3'h0;
    rd_chk(tdc_pkg::OFS_CTL_ONE, 32'h0);
    {mon_en, pll_on} <= 2'b11;
    // Clock loss from each of its three causes, prompt core
    ack_dly <= 4'h0;
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      pins[i] <= 1'b1;
      repeat (6) @(posedge sys_clk);
      pins[i] <= 1'b0;
      rd_chk(tdc_pkg::OFS_CTL_ONE, 32'h2);
      rd_chk(tdc_pkg::OFS_OSC_CTL, 32'h8);
      bus(1'b1, tdc_pkg::OFS_CTL_ONE, 32'h0);
      bus(1'b1, tdc_pkg::OFS_OSC_CTL, 32'h0);
      svc_return();
    end
    // Two soft traps: the higher rank first, the lower after return
    ack_en <= 1'b0;
    pulse(mk(4, 16'h0100));
    pulse(mk(1, 16'h0010));
    repeat (4) @(negedge sys_clk);
    chk(co.trap_level, 32'hc);
    @(posedge sys_clk);
    ack_en <= 1'b1;
    repeat (4) @(posedge sys_clk);
    ack_en <= 1'b0;
    bus(1'b1, tdc_pkg::OFS_CTL_ONE, 32'h20);
    svc_return();
    repeat (4) @(negedge sys_clk);
    chk(co.trap_level, 32'ha);
    @(posedge sys_clk);
    ack_en <= 1'b1;
    repeat (4) @(posedge sys_clk);
    bus(1'b1, tdc_pkg::OFS_CTL_ONE, 32'h0);
    svc_return();
    // Address error while clock loss is in service forces a reset
    @(posedge sys_clk);
    pins[0] <= 1'b1;
    repeat (8) @(posedge sys_clk);
    pins[0] <= 1'b0;
    pulse(mk(5, 16'h0));
    repeat (3) @(posedge sys_clk);
    rd_chk(tdc_pkg::OFS_RST_CTL, 32'h8000);
    rd_chk(tdc_pkg::OFS_CTL_ONE, 32'h0);
    print_verdict();
  end
endmodule
